//--- rtcd_defs.svh
// offsets, field layouts and timing counts of the time digit registers
`ifndef RTCD_DEFS_SVH
`define RTCD_DEFS_SVH

`define RTCD_OFS_SECOND       12'h000
`define RTCD_OFS_MINUTE       12'h004
`define RTCD_OFS_HOUR         12'h008
`define RTCD_OFS_WEEKDAY      12'h00c
`define RTCD_OFS_ALM_MINUTE   12'h010
`define RTCD_OFS_ALM_HOUR     12'h014
`define RTCD_OFS_ALM_WEEKDAY  12'h018
`define RTCD_OFS_FORMAT       12'h01c
`define RTCD_OFS_CONTROL      12'h020
`define RTCD_OFS_STATUS       12'h024
`define RTCD_OFS_MASK         12'h028

`define RTCD_SEC_MAX          7'h59
`define RTCD_MIN_MAX          7'h59
`define RTCD_MIN_NOCMP        7'h7f
`define RTCD_HOUR24_MAX       6'h23
`define RTCD_HOUR12_MAX       5'h11
`define RTCD_HOUR_NOCMP       6'h3f
`define RTCD_PM_BIT           5
`define RTCD_WDAY_SAT         3'h6
`define RTCD_WDAY_NOCMP       3'h7

`define RTCD_CTL_RUN_BIT      0
`define RTCD_CTL_ALM_BIT      1
`define RTCD_ST_SEC_BIT       0
`define RTCD_ST_ALM_BIT       1
`define RTCD_ST_WIDTH         2

`define RTCD_CLK_HZ           20000000
`define RTCD_TICK_CYCLES      (`RTCD_CLK_HZ)

`endif

//--- rtcd_pkg.sv
// types shared by the time digit register block
package rtcd_pkg;
   typedef enum logic [1:0] {
      RTCD_IDLE  = 2'b00,
      RTCD_SETUP = 2'b01,
      RTCD_DONE  = 2'b11
   } rtcd_apb_state_type;

   typedef struct packed {
      logic [6:0] minute;
      logic [5:0] hour;
      logic [2:0] weekday;
   } rtcd_alarm_type;
endpackage : rtcd_pkg

//--- rtcd_alarm_if.sv
// carries current time and alarm targets to the comparator
`timescale 1ns/1ps
`default_nettype none
interface rtcd_alarm_if;
   import rtcd_pkg::*;
   logic [6:0]     minute;
   logic [5:0]     hour;
   logic [2:0]     weekday;
   rtcd_alarm_type target;
   logic           match;
   modport source (output minute, hour, weekday, target, input match);
   modport compare (input minute, hour, weekday, target, output match);
endinterface : rtcd_alarm_if
`default_nettype wire

//--- rtcd_alarm_cmp.sv
// alarm comparator with per-field don't-compare codes
`timescale 1ns/1ps
`default_nettype none
`include "rtcd_defs.svh"
module rtcd_alarm_cmp
   import rtcd_pkg::*;
(
   // time and targets
   rtcd_alarm_if.compare alm
);
   logic min_ok;
   logic hour_ok;
   logic wday_ok;

   // seconds never enter the match
   assign min_ok  = (alm.target.minute == `RTCD_MIN_NOCMP)
                    || (alm.target.minute == alm.minute);
   assign hour_ok = (alm.target.hour == `RTCD_HOUR_NOCMP)
                    || (alm.target.hour == alm.hour);
   assign wday_ok = (alm.target.weekday == `RTCD_WDAY_NOCMP)
                    || (alm.target.weekday == alm.weekday);
   assign alm.match = min_ok && hour_ok && wday_ok;
endmodule : rtcd_alarm_cmp
`default_nettype wire

//--- rtcd_regs.sv
// seconds, minutes, hours and weekday digit registers with alarm bank
`timescale 1ns/1ps
`default_nettype none
`include "rtcd_defs.svh"
module rtcd_regs
   import rtcd_pkg::*;
#(
   parameter int TICK_CYCLES = `RTCD_TICK_CYCLES
)(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // interrupt
   output logic             irq
);
   typedef struct packed {
      logic [31:0]                 tick;
      logic [6:0]                  second;
      logic [6:0]                  minute;
      logic [5:0]                  hour;
      logic [2:0]                  weekday;
      rtcd_alarm_type              alarm;
      logic                        clock_format_select;
      logic                        run;
      logic                        alarm_en;
      logic                        match_d;
      logic [`RTCD_ST_WIDTH-1:0]   status;
      logic [`RTCD_ST_WIDTH-1:0]   mask;
      logic [31:0]                 rdata;
      logic                        err;
   } rtcd_state_type;

   rtcd_state_type r;
   rtcd_state_type next_r;
   rtcd_alarm_if   alm ();

   assign alm.minute  = r.minute;
   assign alm.hour    = r.hour;
   assign alm.weekday = r.weekday;
   assign alm.target  = r.alarm;

   rtcd_alarm_cmp rtcd_alarm_cmp_i (
      .alm (alm)
   );

   // zero wait states: read data and error are captured in the setup cycle,
   // so they stand from flip-flops through the access cycle
   assign pready  = 1'b1;
   assign prdata  = r.rdata;
   assign pslverr = r.err;
   assign irq     = |(r.status & r.mask);

   // one bcd digit step; wraps to zero when the digit passes nine, the caller carries
   function automatic logic [3:0] bcd_inc(input logic [3:0] d);
      bcd_inc = (d == 4'h9) ? 4'h0 : d + 4'h1;
   endfunction : bcd_inc

   logic                      access;
   logic                      wr;
   logic                      rd;
   logic                      sec_tick;
   logic                      sec_wrap;
   logic                      min_wrap;
   logic                      hour_wrap;
   logic                      hit;
   logic [31:0]               rval;
   logic [`RTCD_ST_WIDTH-1:0] events;
   logic [`RTCD_ST_WIDTH-1:0] w1c;

   always_comb begin
      next_r    = r;
      access    = psel && penable;
      wr        = access && pwrite && pstrb[0];
      rd        = psel && !penable && !pwrite;
      sec_tick  = r.run && (r.tick == TICK_CYCLES - 1);
      sec_wrap  = sec_tick && (r.second == `RTCD_SEC_MAX);
      min_wrap  = sec_wrap && (r.minute == `RTCD_MIN_MAX);
      hour_wrap = 1'b0;
      rval      = 32'h0;
      hit       = 1'b1;
      w1c       = '0;

      // seconds prescaler
      if (!r.run || sec_tick) begin
         next_r.tick = 32'h0;
      end else begin
         next_r.tick = r.tick + 32'h1;
      end

      // time counting chain
      if (sec_tick) begin
         next_r.second[3:0] = bcd_inc(r.second[3:0]);
         if (r.second[3:0] == 4'h9) begin
            next_r.second[6:4] = (r.second == `RTCD_SEC_MAX) ? 3'h0 : r.second[6:4] + 3'h1;
         end
      end
      if (sec_wrap) begin
         next_r.minute[3:0] = bcd_inc(r.minute[3:0]);
         if (r.minute[3:0] == 4'h9) begin
            next_r.minute[6:4] = (r.minute == `RTCD_MIN_MAX) ? 3'h0 : r.minute[6:4] + 3'h1;
         end
      end
      if (min_wrap) begin
         if (r.clock_format_select) begin
            hour_wrap = (r.hour == `RTCD_HOUR24_MAX);
            if (hour_wrap) begin
               next_r.hour = 6'h00;
            end else begin
               next_r.hour[3:0] = bcd_inc(r.hour[3:0]);
               if (r.hour[3:0] == 4'h9) begin
                  next_r.hour[5:4] = r.hour[5:4] + 2'h1;
               end
            end
         end else begin
            // 11 rolls to 0 and flips am/pm; day advances after pm 11
            if (r.hour[4:0] == `RTCD_HOUR12_MAX) begin
               next_r.hour[4:0]          = 5'h00;
               next_r.hour[`RTCD_PM_BIT] = !r.hour[`RTCD_PM_BIT];
               hour_wrap                 = r.hour[`RTCD_PM_BIT];
            end else begin
               next_r.hour[3:0] = bcd_inc(r.hour[3:0]);
               if (r.hour[3:0] == 4'h9) begin
                  next_r.hour[4] = 1'b1;
               end
            end
         end
      end
      if (hour_wrap) begin
         next_r.weekday = (r.weekday == `RTCD_WDAY_SAT) ? 3'h0 : r.weekday + 3'h1;
      end

      // alarm fires once on entry to a matching minute
      next_r.match_d = alm.match;
      events[`RTCD_ST_SEC_BIT] = sec_tick;
      events[`RTCD_ST_ALM_BIT] = r.alarm_en && r.run && alm.match && !r.match_d;

      // register access; writes override the counting chain
      if (paddr == `RTCD_OFS_SECOND) begin
         rval = {25'h0, r.second};
         if (wr) begin
            next_r.second = pwdata[6:0];
            next_r.tick   = 32'h0;
         end
      end else if (paddr == `RTCD_OFS_MINUTE) begin
         rval = {25'h0, r.minute};
         if (wr) next_r.minute = pwdata[6:0];
      end else if (paddr == `RTCD_OFS_HOUR) begin
         rval = {26'h0, r.hour};
         if (wr) next_r.hour = pwdata[5:0];
      end else if (paddr == `RTCD_OFS_WEEKDAY) begin
         rval = {29'h0, r.weekday};
         if (wr) next_r.weekday = pwdata[2:0];
      end else if (paddr == `RTCD_OFS_ALM_MINUTE) begin
         rval = {25'h0, r.alarm.minute};
         if (wr) next_r.alarm.minute = pwdata[6:0];
      end else if (paddr == `RTCD_OFS_ALM_HOUR) begin
         rval = {26'h0, r.alarm.hour};
         if (wr) next_r.alarm.hour = pwdata[5:0];
      end else if (paddr == `RTCD_OFS_ALM_WEEKDAY) begin
         rval = {29'h0, r.alarm.weekday};
         if (wr) next_r.alarm.weekday = pwdata[2:0];
      end else if (paddr == `RTCD_OFS_FORMAT) begin
         rval = {31'h0, r.clock_format_select};
         if (wr) next_r.clock_format_select = pwdata[0];
      end else if (paddr == `RTCD_OFS_CONTROL) begin
         rval = {30'h0, r.alarm_en, r.run};
         if (wr) begin
            next_r.run      = pwdata[`RTCD_CTL_RUN_BIT];
            next_r.alarm_en = pwdata[`RTCD_CTL_ALM_BIT];
         end
      end else if (paddr == `RTCD_OFS_STATUS) begin
         rval = {30'h0, r.status};
         if (wr) w1c = pwdata[`RTCD_ST_WIDTH-1:0];
      end else if (paddr == `RTCD_OFS_MASK) begin
         rval = {30'h0, r.mask};
         if (wr) next_r.mask = pwdata[`RTCD_ST_WIDTH-1:0];
      end else begin
         hit = 1'b0;
      end

      // a new event wins over a clear in the same cycle
      next_r.status = (r.status & ~w1c) | events;
      next_r.rdata  = rd ? (hit ? rval : 32'h0) : r.rdata;
      next_r.err    = psel && !penable && !hit;
   end

   // reset clears every field, the time fields included, to zero; software loads them first
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : rtcd_regs
`default_nettype wire

//--- rtcd_regs_props.sv
// checker for the time digit register block
`timescale 1ns/1ps
`default_nettype none
module rtcd_regs_props (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        reset,
   // apb slave side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // interrupt
   input wire logic        irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // read data and error stand in the access cycle itself
   wire logic rd = psel && penable && !pwrite;
   property p_sec;
      rd && paddr == 12'h000 |-> prdata < 32'h60 && prdata[3:0] <= 4'h9;
   endproperty
   a_sec: assert property (p_sec) else $error("seconds read out of range");
   property p_min;
      rd && paddr == 12'h004 |-> prdata < 32'h60 && prdata[3:0] <= 4'h9;
   endproperty
   a_min: assert property (p_min) else $error("minutes read out of range");
   property p_hour;
      rd && paddr == 12'h008 |-> prdata < 32'h40 && prdata[3:0] <= 4'h9;
   endproperty
   a_hour: assert property (p_hour) else $error("hours read out of range");
   property p_wday;
      rd && paddr == 12'h00c |-> prdata < 32'h7;
   endproperty
   a_wday: assert property (p_wday) else $error("weekday read out of range");
   property p_ahour;
      rd && paddr == 12'h014 |-> prdata < 32'h40;
   endproperty
   a_ahour: assert property (p_ahour) else $error("alarm hours wide");
   property p_awday;
      rd && paddr == 12'h018 |-> prdata < 32'h8;
   endproperty
   a_awday: assert property (p_awday) else $error("alarm weekday wide");
   property p_unmap;
      rd && paddr > 12'h028 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   property p_mapped;
      psel && penable && paddr <= 12'h028 && paddr[1:0] == 2'h0 |-> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access flagged");
endmodule : rtcd_regs_props
bind rtcd_regs rtcd_regs_props rtcd_regs_props_i (.sys_clk, .reset, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq);
`default_nettype wire

//--- rtcd_regs_test.sv
// testbench for the time digit register block
`timescale 1ns/1ps
`default_nettype none
module rtcd_regs_test;
   logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   int          n_mismatch, tests_run;
   // a short second keeps each rollover a handful of cycles
   rtcd_regs #(.TICK_CYCLES(8)) rtcd_regs_i (.sys_clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic close_out;
      if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
      // read data and error are taken at the edge that completes the access
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never reassigns psel in this step
      @(posedge sys_clk);
   endtask : apb
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk
   task automatic wirq;
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 40) begin
         @(posedge sys_clk);
         k++;
      end
      if (irq !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
   endtask : wirq
   task automatic s_fields;
      apb(1'b1, 12'h01c, 32'h1);
      apb(1'b1, 12'h000, 32'hffd9);
      rchk(12'h000, 32'h59);
      apb(1'b1, 12'h004, 32'hc5);
      rchk(12'h004, 32'h45);
      apb(1'b1, 12'h008, 32'he3);
      rchk(12'h008, 32'h23);
      apb(1'b1, 12'h00c, 32'hfe);
      rchk(12'h00c, 32'h6);
      apb(1'b1, 12'h010, 32'hff);
      rchk(12'h010, 32'h7f);
      apb(1'b1, 12'h014, 32'hff);
      rchk(12'h014, 32'h3f);
      apb(1'b1, 12'h018, 32'hff);
      rchk(12'h018, 32'h7);
      rchk(12'h02c, 32'h0);
      chk(err, 32'h1);
   endtask : s_fields
   task automatic s_roll(input logic [31:0] fmt, hr, wd, ehr, ewd);
      apb(1'b1, 12'h020, 32'h0);
      apb(1'b1, 12'h028, 32'h1);
      apb(1'b1, 12'h01c, fmt);
      apb(1'b1, 12'h004, 32'h59);
      apb(1'b1, 12'h008, hr);
      apb(1'b1, 12'h00c, wd);
      apb(1'b1, 12'h000, 32'h59);
      apb(1'b1, 12'h024, 32'h3);
      apb(1'b1, 12'h020, 32'h1);
      wirq();
      apb(1'b1, 12'h020, 32'h0);
      rchk(12'h000, 32'h0);
      rchk(12'h004, 32'h0);
      rchk(12'h008, ehr);
      rchk(12'h00c, ewd);
   endtask : s_roll
   task automatic s_alarm;
      apb(1'b1, 12'h028, 32'h2);
      apb(1'b1, 12'h010, 32'h1);
      apb(1'b1, 12'h014, 32'h3f);
      apb(1'b1, 12'h018, 32'h7);
      apb(1'b1, 12'h01c, 32'h1);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h008, 32'h5);
      apb(1'b1, 12'h00c, 32'h1);
      apb(1'b1, 12'h000, 32'h59);
      apb(1'b1, 12'h024, 32'h3);
      apb(1'b1, 12'h020, 32'h3);
      wirq();
      apb(1'b1, 12'h020, 32'h0);
      apb(1'b1, 12'h028, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rchk(12'h024, 32'h3);
      apb(1'b1, 12'h028, 32'h2);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h024, 32'h2);
      chk({31'h0, irq}, 32'h0);
   endtask : s_alarm
   initial begin
      reset      = 1'b1;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 12'h0;
      pwdata     = 32'h0;
      pstrb      = 4'h1;
      n_mismatch = 0;
      tests_run  = 0;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      s_fields();
      s_roll(32'h1, 32'h23, 32'h6, 32'h0, 32'h0);
      s_roll(32'h0, 32'h31, 32'h2, 32'h0, 32'h3);
      s_roll(32'h0, 32'h11, 32'h4, 32'h20, 32'h4);
      s_alarm();
      close_out();
   end
endmodule : rtcd_regs_test
`default_nettype wire
